// >>> core/obd_pkg.sv
//--------------------------------------------------------------------------
// Output bank divider control constants
//--------------------------------------------------------------------------
// Operation
// - The six-bit divide-ratio code maps to fixed ratios from 2 at 000010 to 220 at 111011, with 000000, 000001 and 111100 to 111111 reserved.
// - A newly written divide-ratio code reaches the divider only when the initialise bit toggles, and the old ratio stays until then.
// - With bank power-down at 0 the bank divider runs, and each output runs while its own power-down bit is 0.
// - With bank power-down at 1 the bank divider and every bank output are powered down.
// - With configuration source at 0 the ratio and bank power-down come from the two bank select pins.
// - With configuration source at 1 the ratio and bank power-down come from the registers.
// - With an output power-down bit at 0 that output runs while bank power-down is 0.
// - With an output power-down bit at 1 only that output is powered down.
// - Software writes zero to reserved bits, and their read value is not defined.
// - There are four output power-down bits, indexed 0 to 3.
// - The bank registers sit at offsets 10h to 17h, with the output power-down bits in bit 7 of 14h to 17h.
package obd_pkg;

    //----------------------------------------------------------------------
    // Register map
    //----------------------------------------------------------------------
    localparam logic [7:0] OBD_ADDR_RATIO  = 8'h10;
    localparam logic [7:0] OBD_ADDR_RSVD1  = 8'h11;
    localparam logic [7:0] OBD_ADDR_CTRL   = 8'h12;
    localparam logic [7:0] OBD_ADDR_RSVD3  = 8'h13;
    localparam logic [7:0] OBD_ADDR_OUTPD0 = 8'h14;
    localparam int         OBD_NUM_OUT     = 4;
    localparam int         OBD_CODE_W      = 6;
    localparam int         OBD_RATIO_W     = 8;
    localparam int         OBD_PD_BIT      = 7;
    localparam int         OBD_SRC_BIT     = 0;
    localparam logic [5:0] OBD_RATIO_RST   = 6'h0D;
    localparam logic       OBD_PD_RST      = 1'h0;
    localparam logic       OBD_SRC_RST     = 1'h0;
    localparam logic       OBD_OUTPD_RST   = 1'h0;

    //----------------------------------------------------------------------
    // Bank select pin decode
    //----------------------------------------------------------------------
    localparam logic [5:0] OBD_PIN_CODE0 = 6'h0D;
    localparam logic [5:0] OBD_PIN_CODE1 = 6'h07;
    localparam logic [5:0] OBD_PIN_CODE2 = 6'h09;
    localparam logic [5:0] OBD_PIN_CODE3 = 6'h0D;
    localparam logic [1:0] OBD_PIN_PD    = 2'h3;

    // Ratio code to integer ratio; zero marks a reserved code.
    function automatic logic [7:0] obd_ratio(input logic [5:0] code);
        logic [7:0] r;
        r = 8'h00;
        unique case (code)
            6'h02: r = 8'h02;
            6'h03: r = 8'h03;
            6'h04: r = 8'h04;
            6'h05: r = 8'h05;
            6'h06: r = 8'h06;
            6'h07: r = 8'h08;
            6'h08: r = 8'h09;
            6'h09: r = 8'h0A;
            6'h0A: r = 8'h0C;
            6'h0B: r = 8'h0E;
            6'h0C: r = 8'h0F;
            6'h0D: r = 8'h10;
            6'h0E: r = 8'h12;
            6'h0F: r = 8'h14;
            6'h10: r = 8'h15;
            6'h11: r = 8'h16;
            6'h12: r = 8'h18;
            6'h13: r = 8'h19;
            6'h14: r = 8'h1B;
            6'h15: r = 8'h1C;
            6'h16: r = 8'h1E;
            6'h17: r = 8'h20;
            6'h18: r = 8'h21;
            6'h19: r = 8'h23;
            6'h1A: r = 8'h24;
            6'h1B: r = 8'h28;
            6'h1C: r = 8'h2A;
            6'h1D: r = 8'h2C;
            6'h1E: r = 8'h2D;
            6'h1F: r = 8'h30;
            6'h20: r = 8'h32;
            6'h21: r = 8'h36;
            6'h22: r = 8'h37;
            6'h23: r = 8'h38;
            6'h24: r = 8'h3C;
            6'h25: r = 8'h40;
            6'h26: r = 8'h42;
            6'h27: r = 8'h46;
            6'h28: r = 8'h48;
            6'h29: r = 8'h50;
            6'h2A: r = 8'h54;
            6'h2B: r = 8'h58;
            6'h2C: r = 8'h5A;
            6'h2D: r = 8'h60;
            6'h2E: r = 8'h64;
            6'h2F: r = 8'h6C;
            6'h30: r = 8'h6E;
            6'h31: r = 8'h70;
            6'h32: r = 8'h78;
            6'h33: r = 8'h80;
            6'h34: r = 8'h84;
            6'h35: r = 8'h8C;
            6'h36: r = 8'h90;
            6'h37: r = 8'hA0;
            6'h38: r = 8'hB0;
            6'h39: r = 8'hB4;
            6'h3A: r = 8'hC8;
            6'h3B: r = 8'hDC;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : obd_ratio

endpackage : obd_pkg

// >>> core/obd_bank_ctrl.sv
`timescale 1ns/100ps
module obd_bank_ctrl
    import obd_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clock,
    input  wire logic                    srst,
    // Register port from the serial interface.
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wr_data,
    output logic      [7:0]              reg_rd_data,
    // Strap pins and initialise bit.
    input  wire logic [1:0]              bank_select_pins,
    input  wire logic                    init_clk_bit,
    // Divider and output controls.
    output logic [obd_pkg::OBD_CODE_W-1:0]  applied_code,
    output logic [obd_pkg::OBD_RATIO_W-1:0] divide_ratio,
    output logic                         bank_divider_on,
    output logic [obd_pkg::OBD_NUM_OUT-1:0] bank_output_on
);
    import obd_pkg::*;

    //----------------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------------
    logic [5:0]             bank_divide_ratio_r;
    logic                   bank_power_down_r;
    logic                   bank_config_source_r;
    logic [OBD_NUM_OUT-1:0] output_power_down_r;
    logic                   init_prev_r;
    logic                   init_seen_r;
    logic [5:0]             applied_code_r;
    logic [7:0]             divide_ratio_r;
    logic [7:0]             rd_data_r;
    logic                   div_on_r;
    logic [OBD_NUM_OUT-1:0] out_on_r;

    //----------------------------------------------------------------------
    // Decode
    //----------------------------------------------------------------------
    wire logic       wr_ratio   = reg_wr_en && (reg_addr == OBD_ADDR_RATIO);
    wire logic       wr_ctrl    = reg_wr_en && (reg_addr == OBD_ADDR_CTRL);
    wire logic [7:0] out_index  = reg_addr - OBD_ADDR_OUTPD0;
    wire logic       addr_outpd = (reg_addr >= OBD_ADDR_OUTPD0) &&
                                  (out_index < 8'(OBD_NUM_OUT));

    // Strap decode of the two bank select pins.
    wire logic [5:0] pin_code =
        (bank_select_pins == 2'h0) ? OBD_PIN_CODE0 :
        (bank_select_pins == 2'h1) ? OBD_PIN_CODE1 :
        (bank_select_pins == 2'h2) ? OBD_PIN_CODE2 : OBD_PIN_CODE3;
    wire logic       pin_pd = (bank_select_pins == OBD_PIN_PD);

    // Effective source for ratio and bank power-down.
    wire logic [5:0] eff_code = bank_config_source_r ?
                                bank_divide_ratio_r :
                                pin_code;
    wire logic       eff_pd   = bank_config_source_r ?
                                bank_power_down_r :
                                pin_pd;

    // A change on the initialise bit applies the pending ratio unless its code is reserved.
    wire logic       init_toggle = init_seen_r &&
                                   (init_clk_bit != init_prev_r);
    wire logic [7:0] eff_ratio   = obd_ratio(eff_code);
    wire logic       eff_valid   = (eff_ratio != 8'h00);
    wire logic       apply       = init_toggle && eff_valid;

    // Read mux; reserved bits and unmapped offsets read as zero.
    wire logic [7:0] rd_ratio = {2'h0, bank_divide_ratio_r};
    wire logic [7:0] rd_ctrl  = {bank_power_down_r, 6'h00,
                                 bank_config_source_r};
    wire logic [7:0] rd_outpd = {output_power_down_r[out_index[1:0]],
                                 7'h00};
    wire logic [7:0] rd_mux =
        (reg_addr == OBD_ADDR_RATIO) ? rd_ratio :
        (reg_addr == OBD_ADDR_CTRL)  ? rd_ctrl  :
        addr_outpd                   ? rd_outpd : 8'h00;

    //----------------------------------------------------------------------
    // Writable fields
    //----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            bank_divide_ratio_r  <= OBD_RATIO_RST;
            bank_power_down_r    <= OBD_PD_RST;
            bank_config_source_r <= OBD_SRC_RST;
        end else begin
            if (wr_ratio) begin
                bank_divide_ratio_r <= reg_wr_data[5:0];
            end
            if (wr_ctrl) begin
                bank_power_down_r    <= reg_wr_data[OBD_PD_BIT];
                bank_config_source_r <= reg_wr_data[OBD_SRC_BIT];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < OBD_NUM_OUT; gi++) begin : g_outpd
            wire logic wr_out = reg_wr_en &&
                (reg_addr == OBD_ADDR_OUTPD0 + 8'(gi));
            always_ff @(posedge clock) begin
                if (srst) begin
                    output_power_down_r[gi] <= OBD_OUTPD_RST;
                end else if (wr_out) begin
                    output_power_down_r[gi] <= reg_wr_data[OBD_PD_BIT];
                end
            end
            // Each output obeys its own bit and the bank bit.
            always_ff @(posedge clock) begin
                if (srst) begin
                    out_on_r[gi] <= 1'b1;
                end else begin
                    out_on_r[gi] <= !eff_pd &&
                                    !output_power_down_r[gi];
                end
            end
        end
    endgenerate

    //----------------------------------------------------------------------
    // Applied divider setting
    //----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            init_prev_r    <= 1'b0;
            init_seen_r    <= 1'b0;
            applied_code_r <= OBD_RATIO_RST;
            divide_ratio_r <= obd_ratio(OBD_RATIO_RST);
            div_on_r       <= 1'b1;
        end else begin
            init_prev_r <= init_clk_bit;
            init_seen_r <= 1'b1;
            div_on_r    <= !eff_pd;
            if (apply) begin
                applied_code_r <= eff_code;
                divide_ratio_r <= eff_ratio;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_data_r <= 8'h00;
        end else if (reg_rd_en) begin
            rd_data_r <= rd_mux;
        end
    end

    assign reg_rd_data     = rd_data_r;
    assign applied_code    = applied_code_r;
    assign divide_ratio    = divide_ratio_r;
    assign bank_divider_on = div_on_r;
    assign bank_output_on  = out_on_r;

endmodule : obd_bank_ctrl

// >>> bench/obd_bank_ctrl_asserts.sv
`timescale 1ns/100ps
module obd_bank_ctrl_asserts
    import obd_pkg::*;
(
    // Watched ports.
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic       init_clk_bit,
    input wire logic [5:0] applied_code,
    input wire logic       bank_divider_on,
    input wire logic [3:0] bank_output_on
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire rd_ctl = reg_rd_en && reg_addr == OBD_ADDR_CTRL;
    wire wr_ratio = reg_wr_en && reg_addr == OBD_ADDR_RATIO;
    wire rd_ratio = reg_rd_en && reg_addr == OBD_ADDR_RATIO;
    chk_code_legal: assert property (
        applied_code inside {[6'h02:6'h3B]}) else $error("reserved code");
    chk_code_hold: assert property (
        $stable(init_clk_bit) |=> $stable(applied_code))
        else $error("code moved without toggle");
    chk_bank_off: assert property (
        !bank_divider_on |-> bank_output_on == 4'h0)
        else $error("output on in dead bank");
    chk_out_pd: assert property (
        reg_wr_en && reg_addr == OBD_ADDR_OUTPD0 && reg_wr_data[7]
        |-> ##2 !bank_output_on[0]) else $error("output 0 still on");
    chk_rd_unmap: assert property (
        reg_rd_en && !(reg_addr inside {[8'h10:8'h17]})
        |=> reg_rd_data == 8'h00) else $error("unmapped read not 0");
    chk_rd_hold: assert property (
        !reg_rd_en |=> $stable(reg_rd_data)) else $error("read data moved");
    chk_ctl_rsvd: assert property (
        rd_ctl |=> reg_rd_data[6:1] == 6'h00) else $error("ctrl rsvd set");
    chk_ratio_back: assert property (
        wr_ratio ##1 rd_ratio
        |=> reg_rd_data == ($past(reg_wr_data, 2) & 8'h3F))
        else $error("ratio readback wrong");
    cov_toggle: cover property ($changed(init_clk_bit));
    cov_bank_off: cover property (!bank_divider_on);
    cov_rd_ctl: cover property (rd_ctl);
endmodule : obd_bank_ctrl_asserts
bind obd_bank_ctrl obd_bank_ctrl_asserts u_chk (.clock, .srst, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .init_clk_bit,
    .applied_code, .bank_divider_on, .bank_output_on);

// >>> bench/obd_host_model.sv
`timescale 1ns/100ps
module obd_host_model
    import obd_pkg::*;
(
    // Clock and read data.
    input  wire logic       clock,
    input  wire logic [7:0] reg_rd_data,
    // Register strobes.
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wr_data
);
    initial begin
        {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = 18'h0;
    end
    // Released address and data show a changed value, not the old one.
    task automatic idle();
        @(posedge clock);
        {reg_wr_en, reg_rd_en} <= 2'h0;
        reg_addr    <= ~reg_addr;
        reg_wr_data <= ~reg_wr_data;
    endtask : idle
    // The strobe stays high so a following access can run back to back.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {reg_wr_en, reg_rd_en} <= 2'h2;
        reg_addr    <= a;
        reg_wr_data <= d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        {reg_wr_en, reg_rd_en} <= 2'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1 d = reg_rd_data;
    endtask : rd
    task automatic bank_pd(input logic on);
        wr(OBD_ADDR_CTRL, {on, 7'h01});
        for (int i = 0; i < OBD_NUM_OUT; i++)
            wr(OBD_ADDR_OUTPD0 + 8'(i), {on, 7'h00});
        idle();
    endtask : bank_pd
endmodule : obd_host_model

// >>> bench/obd_bank_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module obd_bank_ctrl_tb;
    import obd_pkg::*;
    logic       clock = 1'b0, srst = 1'b1, init_clk_bit = 1'b0;
    logic [1:0] bank_select_pins = 2'h0;
    logic       reg_wr_en, reg_rd_en, bank_divider_on;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, divide_ratio;
    logic [5:0] applied_code;
    logic [3:0] bank_output_on;
    int         error_cnt = 0, tests_run = 0;
    obd_bank_ctrl u_obd_bank_ctrl (.clock, .srst, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wr_data, .reg_rd_data, .bank_select_pins,
        .init_clk_bit, .applied_code, .divide_ratio, .bank_divider_on,
        .bank_output_on);
    obd_host_model u_obd_host_model (.clock, .reg_rd_data, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wr_data);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic settle();
        u_obd_host_model.idle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle
    task automatic tog();
        u_obd_host_model.idle();
        init_clk_bit <= ~init_clk_bit;
        settle();
    endtask : tog
    task automatic t_apply();
        logic [7:0] d;
        logic [5:0] rs[4] = '{6'h00, 6'h01, 6'h3C, 6'h3F};
        u_obd_host_model.rd(OBD_ADDR_RATIO, d);
        `CHK("ratio reg", 8'h0D, d)
        `CHK("reset ratio", 8'h10, divide_ratio)
        u_obd_host_model.wr(OBD_ADDR_CTRL, 8'h01);
        u_obd_host_model.wr(OBD_ADDR_RATIO, 8'h3B);
        u_obd_host_model.rd(OBD_ADDR_RATIO, d);
        `CHK("ratio back", 8'h3B, d)
        settle();
        `CHK("code held", 6'h0D, applied_code)
        tog();
        `CHK("ratio max", 8'hDC, divide_ratio)
        u_obd_host_model.wr(OBD_ADDR_RATIO, 8'h02);
        tog();
        `CHK("ratio min", 8'h02, divide_ratio)
        for (int i = 0; i < 4; i++) begin
            u_obd_host_model.wr(OBD_ADDR_RATIO, {2'h0, rs[i]});
            tog();
            `CHK("rsvd kept", 6'h02, applied_code)
        end
    endtask : t_apply
    task automatic t_power();
        logic [7:0] d;
        for (int i = 0; i < OBD_NUM_OUT; i++) begin
            u_obd_host_model.wr(OBD_ADDR_OUTPD0 + 8'(i), 8'h80);
            settle();
            `CHK("outs", 4'(4'hF << (i + 1)), bank_output_on)
        end
        u_obd_host_model.rd(8'h17, d);
        `CHK("outpd 3", 8'h80, d)
        u_obd_host_model.bank_pd(1'b1);
        settle();
        `CHK("bank off", 1'b0, bank_divider_on)
        u_obd_host_model.bank_pd(1'b0);
        settle();
        `CHK("all on", 5'h1F, {bank_divider_on, bank_output_on})
    endtask : t_power
    task automatic t_pins();
        logic [7:0] d;
        u_obd_host_model.wr(OBD_ADDR_CTRL, 8'h80);
        bank_select_pins <= 2'h2;
        tog();
        `CHK("pin code", 6'h09, applied_code)
        `CHK("pin ratio", 8'h0A, divide_ratio)
        `CHK("pin on", 1'b1, bank_divider_on)
        bank_select_pins <= 2'h3;
        settle();
        `CHK("pin pd", 1'b0, bank_divider_on)
        `CHK("pin outs", 4'h0, bank_output_on)
        u_obd_host_model.wr(OBD_ADDR_RSVD1, 8'h00);
        u_obd_host_model.rd(OBD_ADDR_RSVD1, d);
        `CHK("rsvd reg", 8'h00, d)
    endtask : t_pins
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        t_apply();
        t_power();
        t_pins();
        end_sim();
    end
endmodule : obd_bank_ctrl_tb
